// ==== verilog/tcp_pkg.sv ====
// constants and carrier types for the torque command path
package tcp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10; // 100 MHz drive clock
  localparam int unsigned FILT_UNIT_NS = 10000; // filter time unit, 0.01 ms
  localparam int unsigned TICK_CYCLES = FILT_UNIT_NS / CLK_PERIOD_NS; // cycles per filter step
  localparam int unsigned TICK_W = 10; // width of the step divider
  localparam logic [9:0] TICK_LAST = 10'(TICK_CYCLES - 1);

  // ----------------------------------------------------------------
  // register indices (plain port, 4-bit address)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_TORQUE_SOURCE_SELECT = 4'h0;
  localparam logic [3:0] ADDR_INTERNAL_TORQUE_SETPOINT = 4'h1;
  localparam logic [3:0] ADDR_ANALOG_CMD_BIAS = 4'h2;
  localparam logic [3:0] ADDR_ANALOG_CMD_FILTER_TIME = 4'h3;
  localparam logic [3:0] ADDR_ANALOG_CMD_DEAD_ZONE = 4'h4;
  localparam logic [3:0] ADDR_ANALOG_CMD_OFFSET_CAL = 4'h5;
  localparam logic [3:0] ADDR_TORQUE_FILTER_TIME = 4'h6;
  localparam logic [3:0] ADDR_LIMIT_SOURCE_SELECT = 4'h7;
  localparam logic [3:0] ADDR_FORWARD_LIMIT_VALUE = 4'h8;
  localparam logic [3:0] ADDR_REVERSE_LIMIT_VALUE = 4'h9;
  localparam logic [3:0] ADDR_DO_FUNCTION = 4'hA;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'hB;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
  localparam logic [3:0] ADDR_TORQUE_OUT = 4'hD;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_SOURCE_SELECT = 16'h0000;
  localparam logic [15:0] RST_SETPOINT = 16'h0000;
  localparam logic [15:0] RST_BIAS = 16'h0000;
  localparam logic [15:0] RST_AI_FILTER_TIME = 16'h00C8;
  localparam logic [15:0] RST_DEAD_ZONE = 16'h0014;
  localparam logic [15:0] RST_OFFSET_CAL = 16'h0000;
  localparam logic [15:0] RST_TORQUE_FILTER_TIME = 16'h0032;
  localparam logic [15:0] RST_LIMIT_SELECT = 16'h0000;
  localparam logic [15:0] RST_FORWARD_LIMIT = 16'h0BB8;
  localparam logic [15:0] RST_REVERSE_LIMIT = 16'h0BB8;
  localparam logic [15:0] RST_DO_FUNCTION = 16'h0000;
  localparam logic [1:0] RST_IRQ = 2'h0;

  // ----------------------------------------------------------------
  // ranges, encodings, scaling
  // ----------------------------------------------------------------
  localparam logic signed [15:0] TORQUE_MAX = 16'sh0BB8; // 300.0 % in 0.1 % steps
  localparam logic signed [15:0] BIAS_MAX = 16'sh1388; // 5000 mV
  localparam logic signed [15:0] OFFSET_MAX = 16'sh01F4; // 500 mV
  localparam logic signed [15:0] DEAD_ZONE_MAX = 16'sh03E8; // 1000 mV
  localparam logic signed [15:0] TQ_FILT_MIN = 16'sh000A; // 0.10 ms
  localparam logic signed [15:0] TQ_FILT_MAX = 16'sh09C4; // 25.00 ms
  localparam logic [15:0] SEL_INTERNAL = 16'h0000;
  localparam logic [15:0] SEL_ANALOG = 16'h0001;
  localparam logic [15:0] DO_FUNC_TORQUE_LIMIT = 16'h008B; // digital output function 139
  localparam int MV_TO_TQ_NUM = 3; // 10 V full scale maps to 300.0 %
  localparam int MV_TO_TQ_DEN = 10;
  localparam int FRAC = 8; // fraction bits of filter state
  localparam int ST_LIMIT_ENTER = 0; // status bit: clamp engaged
  localparam int ST_LIMIT_LEAVE = 1; // status bit: clamp released

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tcp_bus_t;

  typedef struct packed {
    logic valid;
    logic signed [15:0] cmd_mv;
    logic signed [15:0] lim_mv;
  } tcp_ai_t;

endpackage : tcp_pkg

// ==== verilog/tcp_torque_path.sv ====
// torque command path: source select, analog conditioning, filter, limit
//
// Behaviour
// R1 - selector 0 internal setpoint, 1 analog
// R2 - setpoint signed +/-3000, 0.1 % steps, reset 0
// R3 - analog channel one command, two limit
// R4 - subtract bias -5000..5000 mV after offset
// R5 - zero command inside dead zone, default 20
// R6 - zero-drift offset +/-500 mV subtracted always
// R7 - analog channel low-pass before bias, dead zone
// R8 - command low-pass, time 10..2500, default 50
// R9 - clamp to limit when magnitude exceeds it
// R10 - one limit set, never beyond 300.0 %
// R11 - limit selector 0 internal, 1 analog
// R12 - forward limit 0..3000, default 3000
// R13 - reverse limit 0..3000, default 3000
// R14 - analog limit from channel two torque
// R15 - limit flag, output on function 139
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/100ps
module tcp_torque_path (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire tcp_pkg::tcp_bus_t bus,
  output logic [15:0] rd_data,
  // analog samples
  input wire tcp_pkg::tcp_ai_t ai,
  // torque result
  output logic signed [15:0] torque_cmd,
  output logic limit_active,
  output logic do_out,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // saturate a signed value into [lo, hi]
  function automatic logic signed [15:0] sat(input logic signed [31:0] v,
                                             input logic signed [15:0] lo,
                                             input logic signed [15:0] hi);
    if (v < 32'(lo)) begin
      return lo;
    end else if (v > 32'(hi)) begin
      return hi;
    end
    return 16'(v);
  endfunction : sat

  // one first-order low-pass step; tau in filter units, zero passes through
  function automatic logic signed [31:0] lp_step(input logic signed [31:0] y,
                                                 input logic signed [15:0] x,
                                                 input logic [15:0] tau);
    logic signed [31:0] xs;
    xs = 32'(x) <<< tcp_pkg::FRAC;
    if (tau == 16'h0000) begin
      return xs;
    end
    return y + (xs - y) / $signed({16'h0000, tau});
  endfunction : lp_step

  // millivolts to torque in 0.1 % units, saturated to the rated band
  function automatic logic signed [15:0] mv_to_tq(input logic signed [31:0] mv);
    return sat((mv * tcp_pkg::MV_TO_TQ_NUM) / tcp_pkg::MV_TO_TQ_DEN,
               -tcp_pkg::TORQUE_MAX, tcp_pkg::TORQUE_MAX);
  endfunction : mv_to_tq

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] src_sel_q; // command source selector
  logic signed [15:0] setpoint_q; // internal torque setpoint
  logic signed [15:0] bias_q; // analog bias, mV
  logic [15:0] ai_filt_time_q; // analog filter time, 0.01 ms
  logic signed [15:0] dead_zone_q; // dead zone half width, mV
  logic signed [15:0] offset_q; // zero-drift correction, mV
  logic [15:0] tq_filt_time_q; // command filter time, 0.01 ms
  logic [15:0] lim_sel_q; // limit source selector
  logic signed [15:0] fwd_lim_q; // forward limit
  logic signed [15:0] rev_lim_q; // reverse limit magnitude
  logic [15:0] do_func_q; // digital output function code
  logic [1:0] status_q; // sticky events
  logic [1:0] mask_q; // event enables
  logic [1:0] status_set; // events this cycle
  logic signed [15:0] wd; // write data as signed

  assign wd = $signed(bus.wdata);

  // software writes; values saturated to their legal range on entry, except analog filter time, DO function, IRQ mask and the selectors (bit 0 kept)
  always_ff @(posedge clk) begin
    if (rst) begin
      src_sel_q <= tcp_pkg::RST_SOURCE_SELECT;
      setpoint_q <= tcp_pkg::RST_SETPOINT; // R2
      bias_q <= tcp_pkg::RST_BIAS;
      ai_filt_time_q <= tcp_pkg::RST_AI_FILTER_TIME;
      dead_zone_q <= tcp_pkg::RST_DEAD_ZONE; // R5
      offset_q <= tcp_pkg::RST_OFFSET_CAL;
      tq_filt_time_q <= tcp_pkg::RST_TORQUE_FILTER_TIME; // R8
      lim_sel_q <= tcp_pkg::RST_LIMIT_SELECT;
      fwd_lim_q <= tcp_pkg::RST_FORWARD_LIMIT; // R12
      rev_lim_q <= tcp_pkg::RST_REVERSE_LIMIT; // R13
      do_func_q <= tcp_pkg::RST_DO_FUNCTION;
      mask_q <= tcp_pkg::RST_IRQ;
    end else if (bus.wr) begin
      if (bus.addr == tcp_pkg::ADDR_TORQUE_SOURCE_SELECT) begin
        src_sel_q <= {15'h0000, bus.wdata[0]}; // R1
      end else if (bus.addr == tcp_pkg::ADDR_INTERNAL_TORQUE_SETPOINT) begin
        setpoint_q <= sat(32'(wd), -tcp_pkg::TORQUE_MAX, tcp_pkg::TORQUE_MAX); // R2
      end else if (bus.addr == tcp_pkg::ADDR_ANALOG_CMD_BIAS) begin
        bias_q <= sat(32'(wd), -tcp_pkg::BIAS_MAX, tcp_pkg::BIAS_MAX); // R4
      end else if (bus.addr == tcp_pkg::ADDR_ANALOG_CMD_FILTER_TIME) begin
        ai_filt_time_q <= bus.wdata; // R7
      end else if (bus.addr == tcp_pkg::ADDR_ANALOG_CMD_DEAD_ZONE) begin
        dead_zone_q <= sat(32'(wd), 16'sh0000, tcp_pkg::DEAD_ZONE_MAX); // R5
      end else if (bus.addr == tcp_pkg::ADDR_ANALOG_CMD_OFFSET_CAL) begin
        offset_q <= sat(32'(wd), -tcp_pkg::OFFSET_MAX, tcp_pkg::OFFSET_MAX); // R6
      end else if (bus.addr == tcp_pkg::ADDR_TORQUE_FILTER_TIME) begin
        tq_filt_time_q <= sat(32'(bus.wdata), tcp_pkg::TQ_FILT_MIN, tcp_pkg::TQ_FILT_MAX); // R8
      end else if (bus.addr == tcp_pkg::ADDR_LIMIT_SOURCE_SELECT) begin
        lim_sel_q <= {15'h0000, bus.wdata[0]}; // R11
      end else if (bus.addr == tcp_pkg::ADDR_FORWARD_LIMIT_VALUE) begin
        fwd_lim_q <= sat(32'(wd), 16'sh0000, tcp_pkg::TORQUE_MAX); // R12
      end else if (bus.addr == tcp_pkg::ADDR_REVERSE_LIMIT_VALUE) begin
        rev_lim_q <= sat(32'(wd), 16'sh0000, tcp_pkg::TORQUE_MAX); // R13
      end else if (bus.addr == tcp_pkg::ADDR_DO_FUNCTION) begin
        do_func_q <= bus.wdata;
      end else if (bus.addr == tcp_pkg::ADDR_IRQ_MASK) begin
        mask_q <= bus.wdata[1:0];
      end
    end
  end

  // sticky status: a new event wins over a same-cycle write-one clear
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= tcp_pkg::RST_IRQ;
    end else if (bus.wr && bus.addr == tcp_pkg::ADDR_IRQ_STATUS) begin
      status_q <= (status_q & ~bus.wdata[1:0]) | status_set;
    end else begin
      status_q <= status_q | status_set;
    end
  end

  // ----------------------------------------------------------------
  // filter step divider
  // ----------------------------------------------------------------
  logic [tcp_pkg::TICK_W-1:0] tick_cnt_q; // counts clocks per 0.01 ms
  logic tick_q; // one-cycle filter step enable

  // both filters step together so their time constants share one unit
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == tcp_pkg::TICK_LAST) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // analog sampling and conditioning
  // ----------------------------------------------------------------
  logic signed [15:0] ai_cmd_q; // latest command channel sample
  logic signed [15:0] ai_lim_q; // latest limit channel sample
  logic signed [31:0] ai_filt_q; // filtered command channel, FRAC bits
  logic signed [31:0] ai_corr; // after offset and bias, mV
  logic signed [31:0] ai_abs; // magnitude of corrected input
  logic signed [15:0] ana_tq; // analog-derived command

  // both channels arrive together on one strobe; hold the last pair
  always_ff @(posedge clk) begin
    if (rst) begin
      ai_cmd_q <= 16'sh0000;
      ai_lim_q <= 16'sh0000;
    end else if (ai.valid) begin
      ai_cmd_q <= ai.cmd_mv; // R3
      ai_lim_q <= ai.lim_mv; // R3
    end
  end

  // smoothing ahead of correction keeps noise out of the dead-zone test
  always_ff @(posedge clk) begin
    if (rst) begin
      ai_filt_q <= '0;
    end else if (tick_q) begin
      ai_filt_q <= lp_step(ai_filt_q, ai_cmd_q, ai_filt_time_q); // R7
    end
  end

  // offset first, then bias, then dead zone
  always_comb begin
    ai_corr = (ai_filt_q >>> tcp_pkg::FRAC) - 32'(offset_q); // R6
    ai_corr = ai_corr - 32'(bias_q); // R4
    ai_abs = (ai_corr < 0) ? -ai_corr : ai_corr;
    if (ai_abs <= 32'(dead_zone_q)) begin
      ana_tq = 16'sh0000; // R5
    end else begin
      ana_tq = mv_to_tq(ai_corr);
    end
  end

  // ----------------------------------------------------------------
  // source select and command filter
  // ----------------------------------------------------------------
  logic signed [15:0] sel_cmd; // chosen raw command
  logic signed [31:0] tq_filt_q; // filtered command, FRAC bits
  logic signed [15:0] filt_cmd; // filtered command, integer

  assign sel_cmd = (src_sel_q == tcp_pkg::SEL_ANALOG) ? ana_tq : setpoint_q; // R1

  // changing the filter time only alters the step size, no jump at the output
  always_ff @(posedge clk) begin
    if (rst) begin
      tq_filt_q <= '0;
    end else if (tick_q) begin
      tq_filt_q <= lp_step(tq_filt_q, sel_cmd, tq_filt_time_q); // R8
    end
  end

  assign filt_cmd = 16'(tq_filt_q >>> tcp_pkg::FRAC);

  // ----------------------------------------------------------------
  // limit selection and clamp
  // ----------------------------------------------------------------
  logic signed [15:0] ext_lim; // magnitude from the limit channel
  logic signed [15:0] pos_lim; // active forward bound
  logic signed [15:0] neg_lim; // active reverse bound magnitude
  logic signed [15:0] clamp_cmd; // command after clamp
  logic clipped; // clamp engaged this cycle
  logic signed [15:0] torque_cmd_q;
  logic limit_active_q;
  logic do_out_q;
  logic irq_q;
  logic [15:0] rd_data_q;

  // analog limit is symmetric: the sign of the input voltage is ignored
  always_comb begin
    ext_lim = mv_to_tq(32'(ai_lim_q));
    if (ext_lim < 16'sh0000) begin
      ext_lim = -ext_lim; // R14
    end
  end

  // only one set of bounds is ever in force
  assign pos_lim = (lim_sel_q == tcp_pkg::SEL_ANALOG) ? ext_lim : fwd_lim_q; // R10 R12 R14
  assign neg_lim = (lim_sel_q == tcp_pkg::SEL_ANALOG) ? ext_lim : rev_lim_q; // R10 R13 R14

  always_comb begin
    clipped = 1'b0;
    clamp_cmd = filt_cmd;
    if (filt_cmd > pos_lim) begin
      clamp_cmd = pos_lim; // R9
      clipped = 1'b1;
    end else if (filt_cmd < -neg_lim) begin
      clamp_cmd = -neg_lim; // R9
      clipped = 1'b1;
    end
  end

  // events on clamp entry and release
  assign status_set[tcp_pkg::ST_LIMIT_ENTER] = clipped & ~limit_active_q;
  assign status_set[tcp_pkg::ST_LIMIT_LEAVE] = ~clipped & limit_active_q;

  // registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      torque_cmd_q <= 16'sh0000;
      limit_active_q <= 1'b0;
      do_out_q <= 1'b0;
    end else begin
      torque_cmd_q <= clamp_cmd; // R9
      limit_active_q <= clipped; // R15
      do_out_q <= clipped && (do_func_q == tcp_pkg::DO_FUNC_TORQUE_LIMIT); // R15
    end
  end

  // interrupt level follows unmasked status one cycle later
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // read port; unmapped addresses read zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_q <= 16'h0000;
    end else if (!bus.rd) begin
      rd_data_q <= 16'h0000;
    end else if (bus.addr == tcp_pkg::ADDR_TORQUE_SOURCE_SELECT) begin
      rd_data_q <= src_sel_q;
    end else if (bus.addr == tcp_pkg::ADDR_INTERNAL_TORQUE_SETPOINT) begin
      rd_data_q <= setpoint_q;
    end else if (bus.addr == tcp_pkg::ADDR_ANALOG_CMD_BIAS) begin
      rd_data_q <= bias_q;
    end else if (bus.addr == tcp_pkg::ADDR_ANALOG_CMD_FILTER_TIME) begin
      rd_data_q <= ai_filt_time_q;
    end else if (bus.addr == tcp_pkg::ADDR_ANALOG_CMD_DEAD_ZONE) begin
      rd_data_q <= dead_zone_q;
    end else if (bus.addr == tcp_pkg::ADDR_ANALOG_CMD_OFFSET_CAL) begin
      rd_data_q <= offset_q;
    end else if (bus.addr == tcp_pkg::ADDR_TORQUE_FILTER_TIME) begin
      rd_data_q <= tq_filt_time_q;
    end else if (bus.addr == tcp_pkg::ADDR_LIMIT_SOURCE_SELECT) begin
      rd_data_q <= lim_sel_q;
    end else if (bus.addr == tcp_pkg::ADDR_FORWARD_LIMIT_VALUE) begin
      rd_data_q <= fwd_lim_q;
    end else if (bus.addr == tcp_pkg::ADDR_REVERSE_LIMIT_VALUE) begin
      rd_data_q <= rev_lim_q;
    end else if (bus.addr == tcp_pkg::ADDR_DO_FUNCTION) begin
      rd_data_q <= do_func_q;
    end else if (bus.addr == tcp_pkg::ADDR_IRQ_STATUS) begin
      rd_data_q <= {14'h0000, status_q};
    end else if (bus.addr == tcp_pkg::ADDR_IRQ_MASK) begin
      rd_data_q <= {14'h0000, mask_q};
    end else if (bus.addr == tcp_pkg::ADDR_TORQUE_OUT) begin
      rd_data_q <= {limit_active_q, torque_cmd_q[14:0]};
    end else begin
      rd_data_q <= 16'h0000;
    end
  end

  assign rd_data = rd_data_q;
  assign torque_cmd = torque_cmd_q;
  assign limit_active = limit_active_q;
  assign do_out = do_out_q;
  assign irq = irq_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_internal_src;
    src_sel_q == tcp_pkg::SEL_INTERNAL;
  endsequence

  sequence s_over_fwd;
    filt_cmd > pos_lim;
  endsequence

  sequence s_unmasked_event;
    (status_q & mask_q) != 2'h0;
  endsequence

  property p_src_select;
    @(posedge clk) disable iff (rst) s_internal_src |-> sel_cmd == setpoint_q;
  endproperty
  a_src_select: assert property (p_src_select) else $error("internal source not selected"); // R1

  property p_setpoint_range;
    @(posedge clk) disable iff (rst) setpoint_q >= -16'sh0BB8 && setpoint_q <= 16'sh0BB8;
  endproperty
  a_setpoint_range: assert property (p_setpoint_range) else $error("setpoint out of range"); // R2

  property p_dead_zone;
    @(posedge clk) disable iff (rst) ai_abs <= 32'(dead_zone_q) |-> ana_tq == 16'sh0000;
  endproperty
  a_dead_zone: assert property (p_dead_zone) else $error("dead zone not applied"); // R5

  property p_correction;
    @(posedge clk) disable iff (rst)
      ai_corr == (ai_filt_q >>> tcp_pkg::FRAC) - 32'(offset_q) - 32'(bias_q);
  endproperty
  a_correction: assert property (p_correction) else $error("offset or bias not removed"); // R4 R6

  property p_tq_filt_range;
    @(posedge clk) disable iff (rst) tq_filt_time_q >= 16'h000A && tq_filt_time_q <= 16'h09C4;
  endproperty
  a_tq_filt_range: assert property (p_tq_filt_range) else $error("filter time out of range"); // R8

  property p_filter_holds;
    @(posedge clk) disable iff (rst) !tick_q |=> $stable(tq_filt_q);
  endproperty
  a_filter_holds: assert property (p_filter_holds) else $error("filter moved off step"); // R8

  property p_clip_fwd;
    @(posedge clk) disable iff (rst) s_over_fwd |=> torque_cmd_q == $past(pos_lim) && limit_active_q;
  endproperty
  a_clip_fwd: assert property (p_clip_fwd) else $error("forward clamp missed"); // R9 R15

  property p_pass_through;
    @(posedge clk) disable iff (rst) ##1 !limit_active_q |-> torque_cmd_q == $past(filt_cmd);
  endproperty
  a_pass_through: assert property (p_pass_through) else $error("command altered inside limits"); // R9

  property p_rated_band;
    @(posedge clk) disable iff (rst) torque_cmd_q >= -16'sh0BB8 && torque_cmd_q <= 16'sh0BB8;
  endproperty
  a_rated_band: assert property (p_rated_band) else $error("command beyond rated band"); // R10

  property p_ext_limit;
    @(posedge clk) disable iff (rst) lim_sel_q == tcp_pkg::SEL_ANALOG |-> pos_lim == ext_lim && neg_lim == ext_lim;
  endproperty
  a_ext_limit: assert property (p_ext_limit) else $error("analog limit not in force"); // R11 R14

  property p_irq_level;
    @(posedge clk) disable iff (rst) s_unmasked_event ##1 s_unmasked_event |-> irq_q;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

endmodule : tcp_torque_path

// ==== verif/tcp_ai_src.sv ====
// analog sample source standing in for the host's two voltage channels
`timescale 1ns/100ps
module tcp_ai_src (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // voltages set by the bench, mV
  input wire logic signed [15:0] cmd_mv,
  input wire logic signed [15:0] lim_mv,
  // sample carrier toward the drive
  output tcp_pkg::tcp_ai_t ai
);
  // ----------------------------------------------------------------
  // sampler
  // ----------------------------------------------------------------
  logic [6:0] cnt_q; // sample period divider
  // strobe every 128 cycles; between strobes the lines carry inverted
  // values, so latching without the strobe shows up as a wrong command
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 7'h00;
      ai <= '0;
    end else begin
      cnt_q <= cnt_q + 7'h01;
      ai.valid <= (cnt_q == 7'h7F);
      ai.cmd_mv <= (cnt_q == 7'h7F) ? cmd_mv : ~cmd_mv;
      ai.lim_mv <= (cnt_q == 7'h7F) ? lim_mv : ~lim_mv;
    end
  end
endmodule : tcp_ai_src

// ==== verif/test_torque_command_path.sv ====
// self-checking bench for the torque command path
`timescale 1ns/100ps
module test_torque_command_path;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk = 1'b0; // 100 MHz
  logic rst = 1'b1; // held five cycles
  tcp_pkg::tcp_bus_t bus = '0; // register request
  logic [15:0] rd_data;
  tcp_pkg::tcp_ai_t ai;
  logic signed [15:0] torque_cmd;
  logic limit_active;
  logic do_out;
  logic irq;
  logic signed [15:0] cmd_mv = 16'sh0000; // partner voltages
  logic signed [15:0] lim_mv = 16'sh0000;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0; // hang guard
  logic [15:0] d; // last read word
  // reset values of indices 0x0..0xC
  logic [15:0] rst_exp [13] = '{16'h0000, 16'h0000, 16'h0000, 16'h00C8, 16'h0014, 16'h0000,
    16'h0032, 16'h0000, 16'h0BB8, 16'h0BB8, 16'h0000, 16'h0000, 16'h0000};
  // out-of-range writes and their saturated values
  logic [3:0] sat_a [6] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8};
  logic [15:0] sat_w [6] = '{16'h1388, 16'hE890, 16'h07D0, 16'h0258, 16'h0005, 16'h0FA0};
  logic [15:0] sat_e [6] = '{16'h0BB8, 16'hEC78, 16'h03E8, 16'h01F4, 16'h000A, 16'h0BB8};
  always #5 clk = ~clk;
  // ----------------------------------------------------------------
  // design and partner
  // ----------------------------------------------------------------
  tcp_torque_path u_tcp_torque_path (.clk(clk), .rst(rst), .bus(bus), .rd_data(rd_data), .ai(ai),
    .torque_cmd(torque_cmd), .limit_active(limit_active), .do_out(do_out), .irq(irq));
  tcp_ai_src u_tcp_ai_src (.clk(clk), .rst(rst), .cmd_mv(cmd_mv), .lim_mv(lim_mv), .ai(ai));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  // data taken in its one cycle; the word must drop to zero after it
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rd_data;
    @(posedge clk);
    #1 chk(rd_data, 16'h0000);
  endtask : rd
  // filter steps come every TICK_CYCLES clocks
  task automatic ticks(input int n);
    repeat (n * tcp_pkg::TICK_CYCLES) @(posedge clk);
    #1;
  endtask : ticks
  task automatic results;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // ----------------------------------------------------------------
  // timeout, about 71k cycles expected
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      n_errors++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      rd(4'(i));
      chk(d, rst_exp[i]);
    end
    rd(4'hE);
    chk(d, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      wr(sat_a[i], sat_w[i]);
      rd(sat_a[i]);
      chk(d, sat_e[i]);
    end
    // offset and bias pull 215 mV into the dead zone; the analog filter state
    // starts at zero, so switching before its first step would feed -200 mV
    // into the command filter and leave a residue; fill it first, setpoint 0
    wr(4'h4, 16'h0014);
    wr(4'h3, 16'h0000);
    wr(4'h5, 16'h0064);
    wr(4'h2, 16'h0064);
    wr(4'hC, 16'h0001);
    wr(4'h1, 16'h0000);
    cmd_mv <= 16'sd215;
    lim_mv <= 16'sd3000;
    ticks(1);
    wr(4'h0, 16'h0001);
    ticks(5);
    chk(torque_cmd, 16'h0000);
    // analog command 1440 against analog limit 900
    wr(4'h7, 16'h0001);
    cmd_mv <= 16'sd5000;
    ticks(30);
    chk(torque_cmd, 16'd900);
    chk(limit_active, 1'b1);
    chk(do_out, 1'b0);
    chk(irq, 1'b1);
    rd(4'hD);
    chk(d, 16'h8384);
    rd(4'hB);
    chk(d, 16'h0001);
    wr(4'hB, 16'h0003);
    rd(4'hB);
    chk(d, 16'h0000);
    chk(irq, 1'b0);
    // internal setpoint against forward limit 500
    wr(4'hA, tcp_pkg::DO_FUNC_TORQUE_LIMIT);
    wr(4'h8, 16'h01F4);
    wr(4'h1, 16'h07D0);
    wr(4'h7, 16'h0000);
    wr(4'h0, 16'h0000);
    ticks(5);
    chk(torque_cmd, 16'h01F4);
    chk(do_out, 1'b1);
    // swing to -2000 against reverse limit 700: release, then engage
    wr(4'h9, 16'h02BC);
    wr(4'h1, 16'hF830);
    ticks(30);
    chk(torque_cmd, 16'hFD44);
    rd(4'hB);
    chk(d, 16'h0003);
    chk(irq, 1'b1);
    wr(4'hC, 16'h0000);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
    results();
  end
endmodule : test_torque_command_path
